// ---- gpm_pkg.sv ----
// constants, register map and reset values for the port block
package gpm_pkg;

  localparam int          PINS       = 16;
  localparam int          ADDR_W     = 8;
  localparam int          DATA_W     = 32;

  // register byte offsets
  localparam logic [7:0]  OFF_DIR    = 8'h00;
  localparam logic [7:0]  OFF_VAL    = 8'h04;
  localparam logic [7:0]  OFF_LAT    = 8'h08;
  localparam logic [7:0]  OFF_ODC    = 8'h0C;
  localparam logic [7:0]  OFF_DIG    = 8'h10;

  // variant shape: pins present, and pins that also carry an analog function
  localparam logic [15:0] IMPL_MASK  = 16'h7FFF;
  localparam logic [15:0] ANA_MASK   = 16'h000F;

  // reset values
  localparam logic [15:0] RST_DIR    = IMPL_MASK;
  localparam logic [15:0] RST_LAT    = 16'h0000;
  localparam logic [15:0] RST_ODC    = 16'h0000;
  localparam logic [15:0] RST_DIG    = 16'h0000;
  localparam logic [15:0] ZERO16     = 16'h0000;
  localparam logic [31:0] ZERO32     = 32'h0000_0000;

  // byte lanes holding the 16 register bits
  localparam int          LO_LANE    = 0;
  localparam int          HI_LANE    = 1;

  // bus answer sequencing
  typedef enum logic [0:0] {
    GPM_ST_IDLE,
    GPM_ST_ACK
  } gpm_bus_st_t;

endpackage

// ---- gpm_sync.sv ----
// two-flop synchroniser for the pin input levels
module gpm_sync (
  input  wire logic                      pclk,
  input  wire logic                      presetn,
  input  wire logic [gpm_pkg::PINS-1:0]  din,
  output logic      [gpm_pkg::PINS-1:0]  dout
);

  logic [gpm_pkg::PINS-1:0] meta_q;
  logic [gpm_pkg::PINS-1:0] meta_d;
  logic [gpm_pkg::PINS-1:0] dout_d;

  always_comb
  begin
    meta_d = din;
    dout_d = meta_q;
  end

  // first stage is read only by the second stage
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      meta_q <= gpm_pkg::ZERO16;
      dout   <= gpm_pkg::ZERO16;
    end
    else
    begin
      meta_q <= meta_d;
      dout   <= dout_d;
    end
  end

endmodule

// ---- gpm_pin_drv.sv ----
// per-pin output multiplexer and driver stage, registered
module gpm_pin_drv (
  input  wire logic                      pclk,
  input  wire logic                      presetn,
  input  wire logic [gpm_pkg::PINS-1:0]  dig_ok,
  input  wire logic [gpm_pkg::PINS-1:0]  dir,
  input  wire logic [gpm_pkg::PINS-1:0]  lat,
  input  wire logic [gpm_pkg::PINS-1:0]  odc,
  input  wire logic [gpm_pkg::PINS-1:0]  periph_en,
  input  wire logic [gpm_pkg::PINS-1:0]  periph_out,
  input  wire logic [gpm_pkg::PINS-1:0]  periph_oe,
  output logic      [gpm_pkg::PINS-1:0]  pin_out,
  output logic      [gpm_pkg::PINS-1:0]  pin_oe_n
);

  logic [gpm_pkg::PINS-1:0] out_d;
  logic [gpm_pkg::PINS-1:0] oe_n_d;

  genvar i;
  generate
    for (i = 0; i < gpm_pkg::PINS; i++)
    begin : g_pin
      logic own;
      logic src_dat;
      logic src_en;
      logic od;
      assign own     = periph_en[i] & dig_ok[i];
      assign src_dat = own ? periph_out[i] : lat[i];
      assign src_en  = own ? periph_oe[i] : ~dir[i];
      assign od      = odc[i] & ~gpm_pkg::ANA_MASK[i];
      // open drain only pulls low and releases for a high
      assign out_d[i]  = od ? 1'b0 : src_dat;
      assign oe_n_d[i] = ~(dig_ok[i] & src_en & (~od | ~src_dat));
    end
  endgenerate

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pin_out  <= gpm_pkg::ZERO16;
      pin_oe_n <= gpm_pkg::IMPL_MASK | ~gpm_pkg::IMPL_MASK;
    end
    else
    begin
      pin_out  <= out_d;
      pin_oe_n <= oe_n_d;
    end
  end

endmodule

// ---- gpm_port.sv ----
// general purpose port with peripheral pin sharing and an APB register slave
//
// What this block does
// - every pin has its own direction, value and latch bit
// - direction bit 1 makes the pin an input, 0 drives it
// - reset sets the direction bit of every present pin so all pins start as inputs
// - reading pin value returns the sensed pin levels
// - writing pin value stores the data into the output latch
// - reading output latch returns the latch contents
// - writing output latch acts exactly like writing pin value
// - absent pins read zero in latch, direction and pin value
// - open drain bit set: pin pulls low or releases, never drives high
// - pins with an analog function have no open drain option
// - open drain applies to port and peripheral driven outputs alike
// - an enabled peripheral takes the pin ahead of the port
// - muxes choose peripheral or port for data and output enable
// - peripheral owned pin disables port driver, level stays readable
// - converter shared pins work digitally only with their config bit 1
//
// Implementation choices: the APB interface to the registers and the placing of the registers.
module gpm_port (
  input  wire logic                        pclk,
  input  wire logic                        presetn,
  input  wire logic                        psel,
  input  wire logic                        penable,
  input  wire logic                        pwrite,
  input  wire logic [gpm_pkg::ADDR_W-1:0]  paddr,
  input  wire logic [gpm_pkg::DATA_W-1:0]  pwdata,
  input  wire logic [3:0]                  pstrb,
  output logic      [gpm_pkg::DATA_W-1:0]  prdata,
  output logic                             pready,
  output logic                             pslverr,
  input  wire logic [gpm_pkg::PINS-1:0]    pin_in,
  output logic      [gpm_pkg::PINS-1:0]    pin_out,
  output logic      [gpm_pkg::PINS-1:0]    pin_oe_n,
  input  wire logic [gpm_pkg::PINS-1:0]    periph_en,
  input  wire logic [gpm_pkg::PINS-1:0]    periph_out,
  input  wire logic [gpm_pkg::PINS-1:0]    periph_oe,
  output logic      [gpm_pkg::PINS-1:0]    periph_in
);

  ////////////////////////////////////////////////////////////////////////////////
  // declarations

  logic [gpm_pkg::PINS-1:0] dir_q;
  logic [gpm_pkg::PINS-1:0] dir_d;
  logic [gpm_pkg::PINS-1:0] lat_q;
  logic [gpm_pkg::PINS-1:0] lat_d;
  logic [gpm_pkg::PINS-1:0] odc_q;
  logic [gpm_pkg::PINS-1:0] odc_d;
  logic [gpm_pkg::PINS-1:0] dig_q;
  logic [gpm_pkg::PINS-1:0] dig_d;

  logic [gpm_pkg::PINS-1:0] pin_sync;
  logic [gpm_pkg::PINS-1:0] dig_ok;
  logic [gpm_pkg::PINS-1:0] pin_level;
  logic [gpm_pkg::PINS-1:0] periph_in_d;

  gpm_pkg::gpm_bus_st_t      st_q;
  gpm_pkg::gpm_bus_st_t      st_d;
  logic [gpm_pkg::DATA_W-1:0] prdata_d;
  logic                      pready_d;
  logic                      pslverr_d;

  logic                      access;
  logic                      commit;
  logic                      wr;
  logic                      sel_dir;
  logic                      sel_val;
  logic                      sel_lat;
  logic                      sel_odc;
  logic                      sel_dig;
  logic                      mapped;
  logic [gpm_pkg::PINS-1:0]  wmask;
  logic [gpm_pkg::PINS-1:0]  wdat;
  logic [gpm_pkg::PINS-1:0]  rd_bits;

  ////////////////////////////////////////////////////////////////////////////////
  // pin input path

  gpm_sync u_sync (
    .pclk    (pclk),
    .presetn (presetn),
    .din     (pin_in),
    .dout    (pin_sync)
  );

  // a pin is digital when present and, if analog capable, configured digital
  genvar i;
  generate
    for (i = 0; i < gpm_pkg::PINS; i++)
    begin : g_qual
      assign dig_ok[i] = gpm_pkg::IMPL_MASK[i]
                       & (~gpm_pkg::ANA_MASK[i] | dig_q[i]);
      assign pin_level[i] = pin_sync[i] & dig_ok[i];
    end
  endgenerate

  always_comb
  begin
    periph_in_d = pin_level;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      periph_in <= gpm_pkg::ZERO16;
    end
    else
    begin
      periph_in <= periph_in_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // address decode

  always_comb
  begin
    sel_dir = 1'b0;
    sel_val = 1'b0;
    sel_lat = 1'b0;
    sel_odc = 1'b0;
    sel_dig = 1'b0;
    if (paddr == gpm_pkg::OFF_DIR)
    begin
      sel_dir = 1'b1;
    end
    else if (paddr == gpm_pkg::OFF_VAL)
    begin
      sel_val = 1'b1;
    end
    else if (paddr == gpm_pkg::OFF_LAT)
    begin
      sel_lat = 1'b1;
    end
    else if (paddr == gpm_pkg::OFF_ODC)
    begin
      sel_odc = 1'b1;
    end
    else if (paddr == gpm_pkg::OFF_DIG)
    begin
      sel_dig = 1'b1;
    end
  end

  assign mapped = sel_dir | sel_val | sel_lat | sel_odc | sel_dig;
  assign access = psel & penable;
  // the edge that samples pready high completes the transfer
  assign commit = access & (st_q == gpm_pkg::GPM_ST_ACK);
  assign wr     = commit & pwrite & mapped;

  // byte enables gate the two low lanes; upper lanes hold no bits
  assign wmask = {{8{pstrb[gpm_pkg::HI_LANE]}}, {8{pstrb[gpm_pkg::LO_LANE]}}};
  assign wdat  = pwdata[gpm_pkg::PINS-1:0];

  ////////////////////////////////////////////////////////////////////////////////
  // read multiplexer

  always_comb
  begin
    rd_bits = gpm_pkg::ZERO16;
    if (sel_dir)
    begin
      rd_bits = dir_q;
    end
    else if (sel_val)
    begin
      rd_bits = pin_level;
    end
    else if (sel_lat)
    begin
      rd_bits = lat_q;
    end
    else if (sel_odc)
    begin
      rd_bits = odc_q;
    end
    else if (sel_dig)
    begin
      rd_bits = dig_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // bus answer: one wait cycle, then pready with registered read data

  always_comb
  begin
    st_d      = st_q;
    pready_d  = 1'b0;
    pslverr_d = 1'b0;
    prdata_d  = prdata;
    case (st_q)
      gpm_pkg::GPM_ST_IDLE:
      begin
        if (access)
        begin
          st_d      = gpm_pkg::GPM_ST_ACK;
          pready_d  = 1'b1;
          pslverr_d = ~mapped;
          prdata_d  = gpm_pkg::ZERO32;
          if (!pwrite)
          begin
            prdata_d[gpm_pkg::PINS-1:0] = rd_bits;
          end
        end
      end
      gpm_pkg::GPM_ST_ACK:
      begin
        st_d = gpm_pkg::GPM_ST_IDLE;
      end
      default:
      begin
        st_d = gpm_pkg::GPM_ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      st_q    <= gpm_pkg::GPM_ST_IDLE;
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= gpm_pkg::ZERO32;
    end
    else
    begin
      st_q    <= st_d;
      pready  <= pready_d;
      pslverr <= pslverr_d;
      prdata  <= prdata_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // control registers

  // direction: reset leaves every present pin an input
  always_comb
  begin
    dir_d = dir_q;
    if (wr && sel_dir)
    begin
      dir_d = ((wdat & wmask) | (dir_q & ~wmask)) & gpm_pkg::IMPL_MASK;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      dir_q <= gpm_pkg::RST_DIR;
    end
    else
    begin
      dir_q <= dir_d;
    end
  end

  // latch: pin value and latch writes both land in the one latch
  always_comb
  begin
    lat_d = lat_q;
    if (wr && (sel_val || sel_lat))
    begin
      lat_d = ((wdat & wmask) | (lat_q & ~wmask)) & gpm_pkg::IMPL_MASK;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      lat_q <= gpm_pkg::RST_LAT;
    end
    else
    begin
      lat_q <= lat_d;
    end
  end

  // open drain: bits on analog capable pins stay clear
  always_comb
  begin
    odc_d = odc_q;
    if (wr && sel_odc)
    begin
      odc_d = ((wdat & wmask) | (odc_q & ~wmask))
            & gpm_pkg::IMPL_MASK & ~gpm_pkg::ANA_MASK;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      odc_q <= gpm_pkg::RST_ODC;
    end
    else
    begin
      odc_q <= odc_d;
    end
  end

  // digital enable: exists only for converter shared pins
  always_comb
  begin
    dig_d = dig_q;
    if (wr && sel_dig)
    begin
      dig_d = ((wdat & wmask) | (dig_q & ~wmask))
            & gpm_pkg::IMPL_MASK & gpm_pkg::ANA_MASK;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      dig_q <= gpm_pkg::RST_DIG;
    end
    else
    begin
      dig_q <= dig_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // output multiplexers and drivers

  gpm_pin_drv u_drv (
    .pclk       (pclk),
    .presetn    (presetn),
    .dig_ok     (dig_ok),
    .dir        (dir_q),
    .lat        (lat_q),
    .odc        (odc_q),
    .periph_en  (periph_en),
    .periph_out (periph_out),
    .periph_oe  (periph_oe),
    .pin_out    (pin_out),
    .pin_oe_n   (pin_oe_n)
  );

endmodule

// ---- gpm_port_monitor.sv ----
// bus timing and pin ownership checks for the port block
module gpm_port_monitor (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic [15:0] pin_in,
  input wire logic [15:0] pin_out,
  input wire logic [15:0] pin_oe_n,
  input wire logic [15:0] periph_en,
  input wire logic [15:0] periph_out,
  input wire logic [15:0] periph_oe,
  input wire logic [15:0] periph_in
);
  localparam logic [15:0] DIG_PINS = 16'h7FF0;
  logic [1:0] up_q;
  logic [1:0] up_d;
  default clocking @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  // edges seen since reset release, saturating
  always_comb
    up_d = (up_q == 2'h3) ? up_q : up_q + 2'h1;
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
      up_q <= 2'h0;
    else
      up_q <= up_d;
  //////////////////////////////////////////////////////////////////////////////
  a_ready_one_wait:
    assert property (psel && penable && !pready |=> pready) else $error("no answer");
  a_ready_pulse:
    assert property (pready |=> !pready) else $error("answer held");
  a_bus_error:
    assert property (pready |-> pslverr == (paddr > 8'h10 || paddr[1:0] != 2'h0))
      else $error("error flag wrong");
  a_upper_zero:
    assert property (pready |-> prdata[31:16] == 16'h0000 && (!pslverr || prdata == 32'h0))
      else $error("read data bits wrong");
  a_absent_off:
    assert property (pin_oe_n[15]) else $error("absent pin driven");
  a_reset_inputs:
    assert property ($rose(presetn) |-> pin_oe_n == 16'hFFFF)
      else $error("pin driven after reset");
  a_periph_release:
    assert property (up_q != 2'h0 |-> ($past(periph_en) & ~$past(periph_oe) & DIG_PINS
      & ~pin_oe_n) == 16'h0000) else $error("port drives peripheral pin");
  a_periph_low:
    assert property (up_q != 2'h0 |-> ($past(periph_en) & $past(periph_oe) & ~$past(periph_out)
      & DIG_PINS & (pin_oe_n | pin_out)) == 16'h0000) else $error("peripheral low lost");
  a_sync_delay:
    assert property (up_q == 2'h3 |-> (periph_in & DIG_PINS) == ($past(pin_in, 3) & DIG_PINS))
      else $error("pin level delay wrong");
endmodule
bind gpm_port gpm_port_monitor u_mon (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .pin_in(pin_in), .pin_out(pin_out), .pin_oe_n(pin_oe_n), .periph_en(periph_en),
  .periph_out(periph_out), .periph_oe(periph_oe), .periph_in(periph_in));

// ---- gpm_pins_model.sv ----
// external devices on the pins, with a pull-up on every line
module gpm_pins_model (
  input  wire logic [15:0] pin_out,
  input  wire logic [15:0] pin_oe_n,
  input  wire logic [15:0] ext_en,
  input  wire logic [15:0] ext_val,
  output logic      [15:0] pin_in
);
  // released lines float up through the pull-up
  always_comb
    for (int i = 0; i < 16; i++)
      pin_in[i] = !pin_oe_n[i] ? pin_out[i] : (ext_en[i] ? ext_val[i] : 1'b1);
endmodule

// ---- gpm_port_test.sv ----
// self-checking bench for the port block
module gpm_port_test;
  timeunit 1ns;
  timeprecision 100ps;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd_data;
  logic [15:0] pin_in, pin_out, pin_oe_n, periph_en, periph_out, periph_oe, periph_in;
  logic [15:0] ext_en, ext_val;
  logic [3:0]  pstrb;
  int          errors, check_count, cycles;
  gpm_port dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .pin_in(pin_in), .pin_out(pin_out),
    .pin_oe_n(pin_oe_n), .periph_en(periph_en), .periph_out(periph_out),
    .periph_oe(periph_oe), .periph_in(periph_in));
  gpm_pins_model pins_m (.pin_out(pin_out), .pin_oe_n(pin_oe_n), .ext_en(ext_en),
    .ext_val(ext_val), .pin_in(pin_in));
  initial
  begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end
  //////////////////////////////////////////////////////////////////////////////
  task automatic final_report;
    $display("checks %0d errors %0d", check_count, errors);
    if (errors == 0 && check_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp)
    begin
      errors++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // one apb transfer, error flag expected for any address above 8'h10
  task automatic xfer(input logic w, input logic [7:0] a, input logic [15:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {16'h0000, d};
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd_data = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
    chk({31'h0, pslverr}, {31'h0, a > 8'h10});
  endtask
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    xfer(1'b1, a, d);
  endtask
  task automatic rd(input logic [7:0] a, input logic [15:0] exp);
    xfer(1'b0, a, 16'h0000);
    chk(rd_data, {16'h0000, exp});
  endtask
  task automatic pins(input logic [15:0] eo, input logic [15:0] en);
    repeat (2) @(posedge pclk);
    chk({pin_out, pin_oe_n}, {eo, en});
  endtask
  always @(posedge pclk)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      errors++;
      final_report();
    end
  end
  //////////////////////////////////////////////////////////////////////////////
  initial
  begin
    {psel, penable, pwrite, paddr, pwdata, presetn} = '0;
    {periph_en, periph_out, periph_oe, ext_en, ext_val} = '0;
    pstrb = 4'hF;
    errors = 0;
    check_count = 0;
    cycles = 0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    rd(gpm_pkg::OFF_DIR, 16'h7FFF);
    rd(gpm_pkg::OFF_LAT, 16'h0000);
    rd(gpm_pkg::OFF_ODC, 16'h0000);
    wr(gpm_pkg::OFF_DIG, 16'hFFFF);
    rd(gpm_pkg::OFF_DIG, 16'h000F);
    wr(gpm_pkg::OFF_DIR, 16'h0000);
    wr(gpm_pkg::OFF_VAL, 16'hA5A5);
    rd(gpm_pkg::OFF_LAT, 16'h25A5);
    pins(16'h25A5, 16'h8000);
    repeat (3) @(posedge pclk);
    rd(gpm_pkg::OFF_VAL, 16'h25A5);
    wr(gpm_pkg::OFF_LAT, 16'h5A5A);
    xfer(1'b0, gpm_pkg::OFF_LAT, 16'h0000);
    wr(gpm_pkg::OFF_LAT, rd_data[15:0] | 16'h0001);
    rd(gpm_pkg::OFF_LAT, 16'h5A5B);
    wr(gpm_pkg::OFF_DIR, 16'hFFFF);
    ext_en <= 16'hFFFF;
    ext_val <= 16'h1234;
    pins(16'h5A5B, 16'hFFFF);
    repeat (3) @(posedge pclk);
    rd(gpm_pkg::OFF_VAL, 16'h1234);
    rd(gpm_pkg::OFF_LAT, 16'h5A5B);
    pstrb <= 4'h2;
    wr(gpm_pkg::OFF_LAT, 16'h0000);
    pstrb <= 4'hF;
    rd(gpm_pkg::OFF_LAT, 16'h005B);
    ext_en <= 16'h0000;
    wr(gpm_pkg::OFF_DIR, 16'h0000);
    wr(gpm_pkg::OFF_ODC, 16'hFFFF);
    rd(gpm_pkg::OFF_ODC, 16'h7FF0);
    wr(gpm_pkg::OFF_LAT, 16'hFFFF);
    pins(16'h000F, 16'hFFF0);
    wr(gpm_pkg::OFF_LAT, 16'h0000);
    pins(16'h0000, 16'h8000);
    periph_en <= 16'h00F0;
    periph_oe <= 16'h0030;
    periph_out <= 16'h0010;
    pins(16'h0000, 16'h80D0);
    wr(gpm_pkg::OFF_ODC, 16'h0000);
    pins(16'h0010, 16'h80C0);
    repeat (3) @(posedge pclk);
    rd(gpm_pkg::OFF_VAL, 16'h00D0);
    chk({16'h0000, periph_in}, 32'h0000_00D0);
    wr(gpm_pkg::OFF_DIG, 16'h0000);
    pins(16'h0010, 16'h80CF);
    rd(8'h20, 16'h0000);
    wr(8'h24, 16'hFFFF);
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    rd(gpm_pkg::OFF_DIR, 16'h7FFF);
    final_report();
  end
endmodule
